// >>> common/ear_pkg.sv
// Types of the embedded array RAM block: modes, port carriers, state.
// Assumes ear_regs.svh is on the include path.
`include "ear_regs.svh"

package ear_pkg;

  // Storage personality
  typedef enum logic [1:0] {
    EAR_RAM,
    EAR_ROM,
    EAR_DPRAM,
    EAR_FIFO
  } ear_mode_type;

  // Write section request
  typedef struct packed {
    logic                   req;
    logic [`EAR_ADDR_W-1:0] addr;
    logic [`EAR_DATA_W-1:0] data;
  } ear_wr_type;

  // Read section request
  typedef struct packed {
    logic                   req;
    logic [`EAR_ADDR_W-1:0] addr;
  } ear_rd_type;

  // Clocked state of the block, all but the storage array
  typedef struct packed {
    logic [`EAR_ADDR_W-1:0] waddr;
    logic [`EAR_DATA_W-1:0] wdata;
    logic                   wstb;
    logic [`EAR_ADDR_W-1:0] raddr;
    logic [`EAR_DATA_W-1:0] rdata;
    logic [`EAR_PTR_W-1:0]  wptr;
    logic [`EAR_PTR_W-1:0]  rptr;
  } ear_state_type;

endpackage

// >>> common/ear_regs.svh
// Constants of the embedded array RAM block: sizes, width codes, counts.
// Assumes nothing; included by the package and the core module.
`ifndef EAR_REGS_SVH
`define EAR_REGS_SVH

// Storage and port sizes
`define EAR_TOTAL_BITS   4096
`define EAR_ADDR_W       12
`define EAR_DATA_W       16
`define EAR_WORD_W       8
`define EAR_PTR_W        13
`define EAR_WORDS        256

// Width codes: data width is 2**code bits
`define EAR_WCODE_W      3
`define EAR_WCODE_MAX    3'h4

// Fifo capacity in entries at width code zero
`define EAR_FIFO_FULLCNT 13'h1000

`endif

// >>> core/ear_ram.sv
// Embedded array RAM: 4096-bit store with registered ports and fifo mode.
// Assumes one clock; the two sections run at rates set by their enables.
//
// Functional notes
// - Storage is 4096 bits, arranged 1, 2, 4, 8 or 16 bits wide.
// - Acts as RAM, ROM, dual-port RAM, fifo.
// - Inputs and read data are captured in registers.
// - Preloaded pattern serves as 8-in 16-out table.
// - Data words up to sixteen bits wide.
// - Single-port shares one address; dual-port separates.
// - Read and write sections run at independent rates.
// - Each section has its own synchronous clock enable.
// - Write strobe generated internally from clock.
// - Blocks combine via select and ored outputs.
`timescale 1ns/100ps
`default_nettype none
`include "ear_regs.svh"

module ear_ram #(
  parameter logic [`EAR_TOTAL_BITS-1:0] INIT_PATTERN = '0 // Configuration preload
) (
  input  wire logic                     i_mclk,   // Block clock
  input  wire logic                     i_resetn, // Async reset, active low
  input  wire ear_pkg::ear_mode_type    i_mode,   // Storage personality
  input  wire logic [`EAR_WCODE_W-1:0]  i_width,  // Width code, 2**code bits
  input  wire logic                     i_sel,    // Block select for cascading
  input  wire logic                     i_wce,    // Write section clock enable
  input  wire ear_pkg::ear_wr_type      i_wr,     // Write request, address, data
  input  wire logic                     i_rce,    // Read section clock enable
  input  wire ear_pkg::ear_rd_type      i_rd,     // Read request and address
  output logic [`EAR_DATA_W-1:0]        o_rdata,  // Registered read data
  output logic                          o_full,   // Fifo full
  output logic                          o_empty   // Fifo empty
);
  import ear_pkg::*;

  ear_state_type              st_reg;
  ear_state_type              st_next;
  logic [`EAR_DATA_W-1:0]     mem [`EAR_WORDS];
  logic [`EAR_WCODE_W-1:0]    wcode;
  logic                       single_port;
  logic                       fifo_mode;
  logic                       wr_allowed;
  logic                       rd_allowed;
  logic [`EAR_PTR_W-1:0]      fifo_count;
  logic [`EAR_PTR_W-1:0]      fifo_depth;
  logic [`EAR_ADDR_W-1:0]     fifo_wa;
  logic [`EAR_ADDR_W-1:0]     fifo_ra;
  logic [`EAR_DATA_W-1:0]     rd_word;

  // Word index holding a unit of the current width
  function automatic logic [`EAR_WORD_W-1:0] ear_word_idx(
    input logic [`EAR_ADDR_W-1:0]  a,
    input logic [`EAR_WCODE_W-1:0] k
  );
    return `EAR_WORD_W'(a >> (`EAR_WCODE_MAX - k));
  endfunction

  // Bit offset of that unit inside its word
  function automatic logic [3:0] ear_bit_off(
    input logic [`EAR_ADDR_W-1:0]  a,
    input logic [`EAR_WCODE_W-1:0] k
  );
    logic [3:0] lane;
    lane = 4'(a & ((12'h1 << (`EAR_WCODE_MAX - k)) - 12'h1));
    return 4'(lane << k);
  endfunction

  // Low-bit mask of the current width
  function automatic logic [`EAR_DATA_W-1:0] ear_mask(input logic [`EAR_WCODE_W-1:0] k);
    return `EAR_DATA_W'((17'h1 << (5'h1 << k)) - 17'h1);
  endfunction

  // Clamp width code to sixteen bits at most
  assign wcode = (i_width > `EAR_WCODE_MAX) ? `EAR_WCODE_MAX : i_width;

  // Port arrangement from the personality
  assign single_port = (i_mode == EAR_RAM) || (i_mode == EAR_ROM);
  assign fifo_mode   = (i_mode == EAR_FIFO);

  // Fifo occupancy; capacity shrinks as width grows
  assign fifo_depth = `EAR_FIFO_FULLCNT >> wcode;
  assign fifo_count = st_reg.wptr - st_reg.rptr;
  assign o_full     = fifo_count == fifo_depth;
  assign o_empty    = fifo_count == '0;
  assign fifo_wa    = st_reg.wptr[`EAR_ADDR_W-1:0] & (fifo_depth[`EAR_ADDR_W-1:0] - 12'h1);
  assign fifo_ra    = st_reg.rptr[`EAR_ADDR_W-1:0] & (fifo_depth[`EAR_ADDR_W-1:0] - 12'h1);

  // Write refused in ROM and on a full fifo
  assign wr_allowed = i_sel && (i_mode != EAR_ROM) && !(fifo_mode && o_full);
  assign rd_allowed = !(fifo_mode && o_empty);

  // Unit addressed by the read address register
  assign rd_word = (mem[ear_word_idx(st_reg.raddr, wcode)] >> ear_bit_off(st_reg.raddr, wcode))
                   & ear_mask(wcode);

  // Next state of both sections
  always_comb begin
    st_next      = st_reg;
    st_next.wstb = 1'b0;
    if (i_wce) begin
      st_next.wstb  = i_wr.req && wr_allowed;
      st_next.waddr = fifo_mode ? fifo_wa : i_wr.addr;
      st_next.wdata = i_wr.data & ear_mask(wcode);
      if (fifo_mode && i_wr.req && wr_allowed) begin
        st_next.wptr = st_reg.wptr + 13'h1;
      end
    end
    if (i_rce) begin
      st_next.rdata = i_sel ? rd_word : '0;
      if (i_rd.req && rd_allowed) begin
        st_next.raddr = fifo_mode ? fifo_ra : (single_port ? i_wr.addr : i_rd.addr);
        if (fifo_mode) begin
          st_next.rptr = st_reg.rptr + 13'h1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Preload at configuration, giving table lookup
  initial begin
    for (int i = 0; i < `EAR_WORDS; i++) begin
      mem[i] = INIT_PATTERN[i*`EAR_DATA_W +: `EAR_DATA_W];
    end
  end

  // Self-timed write from the captured strobe
  // Plain always: the preload above also fills the array
  always @(posedge i_mclk) begin
    if (st_reg.wstb) begin
      mem[ear_word_idx(st_reg.waddr, wcode)] <=
        (mem[ear_word_idx(st_reg.waddr, wcode)]
         & ~(ear_mask(wcode) << ear_bit_off(st_reg.waddr, wcode)))
        | (st_reg.wdata << ear_bit_off(st_reg.waddr, wcode));
    end
  end

  assign o_rdata = st_reg.rdata;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_wstb_cause;
    st_reg.wstb |-> $past(i_wce && i_wr.req && i_sel);
  endproperty
  a_wstb_cause: assert property (p_wstb_cause) else $error("strobe without write");

  property p_rom_no_write;
    (i_mode == EAR_ROM) ##1 (i_mode == EAR_ROM) |-> !st_reg.wstb;
  endproperty
  a_rom_no_write: assert property (p_rom_no_write) else $error("write in ROM");

  property p_hold_rdata;
    !i_rce |=> $stable(o_rdata);
  endproperty
  a_hold_rdata: assert property (p_hold_rdata) else $error("rdata moved");

  property p_hold_raddr;
    !i_rce |=> $stable(st_reg.raddr);
  endproperty
  a_hold_raddr: assert property (p_hold_raddr) else $error("raddr moved");

  property p_full_block;
    fifo_mode && o_full && i_wce |=> !st_reg.wstb;
  endproperty
  a_full_block: assert property (p_full_block) else $error("write on full");

  property p_flags;
    !(o_full && o_empty);
  endproperty
  a_flags: assert property (p_flags) else $error("full and empty");

  property p_strobe_one;
    st_reg.wstb && !i_wce |=> !st_reg.wstb;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe stuck");

  property p_read_lat;
    i_rce |=> o_rdata == $past(i_sel ? rd_word : 16'h0000);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data wrong");

  property p_width;
    $stable(wcode) && (wcode != `EAR_WCODE_MAX) |-> (o_rdata & ~ear_mask(wcode)) == '0;
  endproperty
  a_width: assert property (p_width) else $error("data wider than width");

endmodule
`default_nettype wire

// >>> testbench/ear_fabric.sv
// Fabric-side user logic model driving write and read requests.
// Assumes the block clock and read data are wired in by the bench.
`timescale 1ns/100ps
`default_nettype none
`include "ear_regs.svh"

module ear_fabric (
  input  wire logic [`EAR_DATA_W-1:0] i_rdata, // Read data from block
  input  wire logic                   i_mclk,  // Block clock
  output var  ear_pkg::ear_wr_type    o_wr,    // Write request
  output var  logic                   o_wce,   // Write clock enable
  output var  ear_pkg::ear_rd_type    o_rd,    // Read request
  output var  logic                   o_rce    // Read clock enable
);
  import ear_pkg::*;

  // Idle values at time zero
  initial begin
    o_wr  = '0;
    o_wce = 1'b0;
    o_rd  = '0;
    o_rce = 1'b1;
  end

  // One write, held one edge; stale fields inverted on release
  task automatic write(input logic [11:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_wce <= 1'b1;
    o_wr  <= '{1'b1, a, d};
    @(posedge i_mclk);
    o_wce <= 1'b0;
    o_wr  <= '{1'b0, ~a, ~d};
  endtask

  // One read; request sampled at the next edge, data taken 1 ns after the edge after that
  task automatic read(input logic [11:0] ra, wa, output logic [15:0] d);
    @(posedge i_mclk);
    o_rd      <= '{1'b1, ra};
    o_wr.addr <= wa;
    @(posedge i_mclk);
    o_rd <= '{1'b0, ~ra};
    @(posedge i_mclk);
    #1 d = i_rdata;
  endtask

  // Read section clock enable, changed just after an edge
  task automatic set_rce(input logic v);
    @(posedge i_mclk);
    o_rce <= v;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_embedded_ram_block.sv
// Self-checking bench of the embedded array RAM block.
// Assumes the core, package and fabric model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ear_regs.svh"

module test_embedded_ram_block;
  import ear_pkg::*;
  localparam logic [`EAR_TOTAL_BITS-1:0] PAT = 4096'hbeef << 48;
  logic mclk = 1'b0, resetn = 1'b0, sel = 1'b1;
  logic [2:0] width = 3'h4;
  ear_mode_type mode = EAR_FIFO;
  ear_wr_type wr;
  ear_rd_type rd;
  logic wce, rce, full, empty;
  logic [15:0] rdata, d;
  int num_errors = 0, cmp_count = 0;

  ear_ram #(.INIT_PATTERN(PAT)) DUT (.i_mclk(mclk), .i_resetn(resetn),
    .i_mode(mode), .i_width(width), .i_sel(sel), .i_wce(wce), .i_wr(wr),
    .i_rce(rce), .i_rd(rd), .o_rdata(rdata), .o_full(full), .o_empty(empty));
  ear_fabric fab (.i_rdata(rdata), .i_mclk(mclk), .o_wr(wr), .o_wce(wce),
    .o_rd(rd), .o_rce(rce));

  // Clock, 100 ns period
  initial begin
    forever #50 mclk = ~mclk;
  end

  // Compare and count
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // Reset for 8 cycles with a new mode and width code
  task automatic do_reset(ear_mode_type m, logic [2:0] w = 3'h4);
    @(posedge mclk);
    resetn <= 1'b0;
    mode   <= m;
    width  <= w;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
  endtask

  // Fifo order and empty flag
  task automatic t_fifo;
    do_reset(EAR_FIFO);
    #1 check("empty", {15'h0, empty}, 16'h1);
    fab.write(12'h9, 16'h1111);
    fab.write(12'h9, 16'h2222);
    @(posedge mclk);
    #1 check("empty", {15'h0, empty}, 16'h0);
    check("full", {15'h0, full}, 16'h0);
    fab.read(12'h3, 12'h3, d);
    check("pop1", d, 16'h1111);
    fab.read(12'h3, 12'h3, d);
    check("pop2", d, 16'h2222);
    check("empty", {15'h0, empty}, 16'h1);
  endtask

  // Writes two cycles apart, single-port reads, block select
  task automatic t_ram;
    do_reset(EAR_RAM);
    fab.write(12'h5, 16'h1234);
    fab.write(12'h6, 16'habcd);
    fab.read(12'h0, 12'h5, d);
    check("ram5", d, 16'h1234);
    fab.read(12'h0, 12'h6, d);
    check("ram6", d, 16'habcd);
    @(posedge mclk);
    sel <= 1'b0;
    fab.write(12'h5, 16'hffff);
    fab.read(12'h0, 12'h5, d);
    check("unsel", d, 16'h0000);
    @(posedge mclk);
    sel <= 1'b1;
    fab.read(12'h0, 12'h5, d);
    check("sel", d, 16'h1234);
  endtask

  // Byte units at width code 3, other byte kept, high data bits dropped
  task automatic t_width;
    do_reset(EAR_RAM, 3'h3);
    fab.write(12'h00b, 16'hff99);
    fab.read(12'h0, 12'h00a, d);
    check("lowbyte", d, 16'h0034);
    fab.read(12'h0, 12'h00b, d);
    check("highbyte", d, 16'h0099);
  endtask

  // Fill the fifo at full width, refused push, oldest entry first out
  task automatic t_full;
    do_reset(EAR_FIFO);
    for (int i = 0; i < `EAR_TOTAL_BITS / `EAR_DATA_W; i++) begin
      fab.write(12'h0, 16'h0100 + 16'(i));
    end
    @(posedge mclk);
    #1 check("full", {15'h0, full}, 16'h1);
    fab.write(12'h0, 16'hdead);
    fab.read(12'h0, 12'h0, d);
    check("oldest", d, 16'h0100);
    check("notfull", {15'h0, full}, 16'h0);
  endtask

  // Preload read, write refused
  task automatic t_rom;
    do_reset(EAR_ROM);
    fab.write(12'h3, 16'h0000);
    fab.read(12'h0, 12'h3, d);
    check("rom", d, 16'hbeef);
  endtask

  // Separate read address, read enable gap
  task automatic t_dp;
    do_reset(EAR_DPRAM);
    fab.write(12'h7, 16'ha5a5);
    fab.read(12'h7, 12'h5, d);
    check("dp", d, 16'ha5a5);
    fab.set_rce(1'b0);
    fab.read(12'h5, 12'h5, d);
    check("rce", d, 16'ha5a5);
    fab.set_rce(1'b1);
  endtask

  // Verdict
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_fifo();
    t_ram();
    t_width();
    t_rom();
    t_dp();
    t_full();
    end_sim();
  end

  // Watchdog, several times the expected run of some 630 cycles
  initial begin
    #300000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
